//--- logic/tfem_top.v
`include "tfem_map.vh"
`default_nettype none
module tfem_top #(
   parameter TS_W = 32,
   parameter CNT_W = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire [3:0] pulse_gen_level,
   input wire frame_valid,
   input wire trigger_in_drop,
   input wire queue_full_drop,
   output reg input_rate_lost_event,
   output reg frame_missed_event,
   output reg output_pulse_event,
   output reg [TS_W-1:0] event_timestamp,
   output wire irq
);
   // ****************************************
   // pin synchronisation and edges
   // ****************************************
   wire [6:0] pins_s;
   wire [6:0] pins_rise;
   tfem_sync #(.W(7)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({queue_full_drop, trigger_in_drop, frame_valid, pulse_gen_level}),
      .q(pins_s)
   );
   tfem_edge #(.W(7)) u_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .lvl(pins_s),
      .rise(pins_rise)
   );
   wire [3:0] gen_start = pins_rise[3:0];
   wire frame_start = pins_rise[4];
   wire drop_rate = pins_rise[5];
   wire drop_queue = pins_rise[6];

   // ****************************************
   // registers
   // ****************************************
   reg [5:0] ctrl_r;
   reg lost_flag_r;
   reg overrun_r;
   reg [CNT_W-1:0] count_r;
   reg [2:0] irq_stat_r;
   reg [2:0] irq_mask_r;
   reg [TS_W-1:0] tstamp_r;
   reg armed_r;
   reg frame_seen_r;

   wire [1:0] stats_source_select = ctrl_r[`TFEM_CTRL_STATS_LSB+1:`TFEM_CTRL_STATS_LSB];
   wire [1:0] output_event_source_select = ctrl_r[`TFEM_CTRL_EVSEL_LSB+1:`TFEM_CTRL_EVSEL_LSB];
   wire queue_en = ctrl_r[`TFEM_CTRL_QUEUE_EN];
   wire gen_mode = ctrl_r[`TFEM_CTRL_GEN_MODE];

   function pick;
      input [3:0] v;
      input [1:0] s;
      begin
         pick = v[s];
      end
   endfunction

   wire stats_start = pick(gen_start, stats_source_select);
   wire out_start = pick(gen_start, output_event_source_select);

   // ****************************************
   // ahb-lite slave
   // ****************************************
   reg ph_wr_r;
   reg ph_rd_r;
   reg [7:0] ph_addr_r;
   wire take = hsel & hready & htrans[1];
   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_r <= 1'b0;
         ph_rd_r <= 1'b0;
         ph_addr_r <= 8'h00;
      end else begin
         ph_wr_r <= take & hwrite;
         ph_rd_r <= take & ~hwrite;
         ph_addr_r <= haddr[7:0];
      end
   end

   wire wr_ctrl = ph_wr_r && (ph_addr_r == `TFEM_OFS_CTRL);
   wire wr_cmd = ph_wr_r && (ph_addr_r == `TFEM_OFS_CMD);
   wire wr_mask = ph_wr_r && (ph_addr_r == `TFEM_OFS_IRQ_MASK);
   wire rd_istat = take && !hwrite && (haddr[7:0] == `TFEM_OFS_IRQ_STAT);
   wire clr_lost = wr_cmd & hwdata[`TFEM_CMD_CLR_LOST];
   wire clr_over = wr_cmd & hwdata[`TFEM_CMD_CLR_OVERRUN];
   wire clr_cnt = wr_cmd & hwdata[`TFEM_CMD_CLR_COUNT];

   // read data registered at address phase, so it stands in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         case (haddr[7:0])
            `TFEM_OFS_CTRL: hrdata <= {26'h0, ctrl_r};
            `TFEM_OFS_STATUS: hrdata <= {30'h0, overrun_r, lost_flag_r};
            `TFEM_OFS_COUNT: hrdata <= {{(32-CNT_W){1'b0}}, count_r}; // see RULE_14
            `TFEM_OFS_IRQ_STAT: hrdata <= {29'h0, irq_stat_r};
            `TFEM_OFS_IRQ_MASK: hrdata <= {29'h0, irq_mask_r};
            `TFEM_OFS_TSTAMP: hrdata <= tstamp_r[31:0];
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `TFEM_CTRL_RESET; // see RULE_10
         irq_mask_r <= `TFEM_MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= hwdata[5:0]; // see RULE_10
         end
         if (wr_mask) begin
            irq_mask_r <= hwdata[2:0];
         end
      end
   end

   // ****************************************
   // detection
   // ****************************************
   // not for very fast cameras: latency may push a frame past the next trigger
   wire missed = stats_start & armed_r & ~frame_seen_r & ~frame_start; // see RULE_12
   // drops come from the trigger stage; queue mode counts only overflow drops
   // generator mode never reports a lost trigger; see RULE_06
   wire rate_drop = gen_mode ? 1'b0 : (queue_en ? drop_queue : drop_rate); // see RULE_05

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed_r <= 1'b0;
         frame_seen_r <= 1'b0;
         lost_flag_r <= 1'b0;
         overrun_r <= 1'b0;
         count_r <= {CNT_W{1'b0}};
      end else begin
         if (stats_start) begin
            armed_r <= 1'b1;
            frame_seen_r <= 1'b0;
         end else if (frame_start) begin
            frame_seen_r <= 1'b1;
         end
         // set wins over clear for both flags; the count clear wins over an increment
         if (missed) begin
            lost_flag_r <= 1'b1; // see RULE_03
         end else if (clr_lost) begin
            lost_flag_r <= 1'b0; // see RULE_03
         end
         if (rate_drop) begin
            overrun_r <= 1'b1; // see RULE_13
         end else if (clr_over) begin
            overrun_r <= 1'b0; // see RULE_13
         end
         if (clr_cnt) begin
            count_r <= {CNT_W{1'b0}}; // see RULE_14
         end else if (stats_start) begin
            count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1}; // see RULE_14
         end
      end
   end

   // ****************************************
   // events and interrupt
   // ****************************************
   wire [2:0] ev_now = {out_start, missed, rate_drop};

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tstamp_r <= {TS_W{1'b0}};
         event_timestamp <= {TS_W{1'b0}};
         input_rate_lost_event <= 1'b0;
         frame_missed_event <= 1'b0;
         output_pulse_event <= 1'b0;
         irq_stat_r <= 3'h0;
      end else begin
         tstamp_r <= tstamp_r + {{(TS_W-1){1'b0}}, 1'b1};
         input_rate_lost_event <= rate_drop; // see RULE_04
         frame_missed_event <= missed; // see RULE_08, see RULE_09
         output_pulse_event <= out_start; // see RULE_11
         if (|ev_now) begin // see RULE_07
            event_timestamp <= tstamp_r; // see RULE_15
         end
         // new events win over the read clear
         irq_stat_r <= (rd_istat ? 3'h0 : irq_stat_r) | ev_now; // see RULE_09
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

//--- include/tfem_map.vh
// Summary of operation
// RULE_01: software points the statistics source at the generator that drives the camera trigger.
// RULE_02: software starts acquisition before enabling triggers, or early pulses are lost.
// RULE_03: the frame-response-lost flag stays set until its clear command returns it to no.
// RULE_04: each input trigger dropped for exceeding the max output rate raises one lost event.
// RULE_05: with the trigger queue enabled, a lost event is raised only when the queue is full.
// RULE_06: in internal generator mode no lost-trigger event is ever raised.
// RULE_07: every event carries a timestamp and no other payload.
// RULE_08: every output trigger pulse without a frame response raises a frame-missed event.
// RULE_09: with proper setup exactly one frame-missed event is raised per lost frame.
// RULE_10: a read-write selector picks one of generators 0 to 3 for the output event, reset 0.
// RULE_11: an output pulse event is raised at the start of every pulse of the selected generator.
// RULE_12: the lost flag sets when two trigger starts pass with no valid frame between them.
// RULE_13: the rate overrun flag is sticky, unchanged by reads, reset only by its clear command.
// RULE_14: a read-only 16-bit counter counts pulses of the statistics source; a command clears it.
// RULE_15: each event is a one-cycle strobe with a timestamp captured on the same edge.
`ifndef TFEM_MAP_VH
`define TFEM_MAP_VH
`define TFEM_OFS_CTRL 8'h00
`define TFEM_OFS_STATUS 8'h04
`define TFEM_OFS_CMD 8'h08
`define TFEM_OFS_COUNT 8'h0c
`define TFEM_OFS_IRQ_STAT 8'h10
`define TFEM_OFS_IRQ_MASK 8'h14
`define TFEM_OFS_TSTAMP 8'h18
`define TFEM_CTRL_STATS_LSB 0
`define TFEM_CTRL_EVSEL_LSB 2
`define TFEM_CTRL_QUEUE_EN 4
`define TFEM_CTRL_GEN_MODE 5
`define TFEM_ST_LOST 0
`define TFEM_ST_OVERRUN 1
`define TFEM_CMD_CLR_LOST 0
`define TFEM_CMD_CLR_OVERRUN 1
`define TFEM_CMD_CLR_COUNT 2
`define TFEM_EV_TRIG_LOST 0
`define TFEM_EV_FRAME_MISSED 1
`define TFEM_EV_OUT_PULSE 2
`define TFEM_SEL_RESET 2'h0
`define TFEM_CTRL_RESET 6'h00
`define TFEM_MASK_RESET 3'h0
`endif

//--- logic/tfem_sync.v
`default_nettype none
module tfem_sync #(
   parameter W = 4
) (
   input wire hclk,
   input wire hresetn,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_r;
   // first stage is read only by the second
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- logic/tfem_edge.v
`default_nettype none
module tfem_edge #(
   parameter W = 4
) (
   input wire hclk,
   input wire hresetn,
   input wire [W-1:0] lvl,
   output wire [W-1:0] rise
);
   reg [W-1:0] prev_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_r <= {W{1'b0}};
      end else begin
         prev_r <= lvl;
      end
   end
   assign rise = lvl & ~prev_r;
endmodule
`default_nettype wire

//--- dv/tfem_monitor.sv
`default_nettype none
module tfem_monitor #(
   parameter TS_W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [3:0] pulse_gen_level,
   input wire logic trigger_in_drop,
   input wire logic queue_full_drop,
   input wire logic input_rate_lost_event,
   input wire logic frame_missed_event,
   input wire logic output_pulse_event,
   input wire logic [TS_W-1:0] event_timestamp
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // event checks and the unmapped-read check
   // ****************
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic ev;
   assign ev = input_rate_lost_event | frame_missed_event | output_pulse_event;
   sequence s_rd_far;
      hsel && hready && htrans[1] && !hwrite && haddr == 32'h20;
   endsequence
   a_far_read_zero: assert property (s_rd_far |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_out_one_cycle: assert property (output_pulse_event |=> !output_pulse_event)
      else $error("pulse event too long");
   a_miss_one_cycle: assert property (frame_missed_event |=> !frame_missed_event)
      else $error("missed event too long");
   a_lost_one_cycle: assert property (input_rate_lost_event |=> !input_rate_lost_event)
      else $error("lost event too long");
   a_stamp_holds: assert property (!ev |-> $stable(event_timestamp))
      else $error("stamp moved without event");
   a_stamp_fresh: assert property (ev |-> event_timestamp != $past(event_timestamp))
      else $error("stamp not captured");
   a_out_has_edge: assert property (output_pulse_event |->
      |(pulse_gen_level & ~$past(pulse_gen_level, 7)))
      else $error("pulse event without start");
   a_miss_has_edge: assert property (frame_missed_event |->
      |(pulse_gen_level & ~$past(pulse_gen_level, 7)))
      else $error("missed event without start");
   a_lost_has_drop: assert property (input_rate_lost_event |->
      (trigger_in_drop && !$past(trigger_in_drop, 7)) ||
      (queue_full_drop && !$past(queue_full_drop, 7)))
      else $error("lost event without drop");
endmodule
bind tfem_top tfem_monitor #(.TS_W(TS_W)) u_mon(.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .pulse_gen_level, .trigger_in_drop, .queue_full_drop,
   .input_rate_lost_event, .frame_missed_event, .output_pulse_event, .event_timestamp);
`default_nettype wire

//--- dv/tfem_cam.sv
`default_nettype none
module tfem_cam (
   input wire logic clk,
   input wire logic trig,
   input wire logic skip,
   output logic frame
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // camera answer
   // ****************
   logic trig_q = 1'b0;
   logic [3:0] cnt = 4'h0;
   // acquiring from time zero, so a trigger start is lost here only while skip is set
   always @(posedge clk) begin
      trig_q <= trig;
      if (trig && !trig_q && !skip)
         cnt <= 4'h5;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
   assign frame = (cnt == 4'h3) || (cnt == 4'h2);
endmodule
`default_nettype wire

//--- dv/testbench.sv
`include "tfem_map.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // bench
   // ****************
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, skip = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, tstamp;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [5:0] pins = 6'h0;
   logic hready, hresp, fv, ev_lost, ev_miss, ev_out, irq, rd_ph = 1'b0;
   logic [31:0] exp_q[$];
   int n_mismatch = 0, total_checks = 0, n_lost = 0, n_miss = 0, n_out = 0;
   int e_lost = 0, e_miss = 0, e_out = 0;
   always #10 hclk = ~hclk;
   tfem_top u_dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout(hready), .hresp, .pulse_gen_level(pins[3:0]), .frame_valid(fv),
      .trigger_in_drop(pins[4]), .queue_full_drop(pins[5]), .input_rate_lost_event(ev_lost),
      .frame_missed_event(ev_miss), .output_pulse_event(ev_out), .event_timestamp(tstamp),
      .irq);
   tfem_cam u_cam(.clk(hclk), .trig(pins[0]), .skip, .frame(fv));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      if (!w) exp_q.push_back(d);
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask
   task automatic tick(input int i);
      pins[i] <= 1'b1;
      repeat (10) @(posedge hclk);
      pins[i] <= 1'b0;
      repeat (12 + $urandom % 6) @(posedge hclk);
   endtask
   task automatic irq_is(input logic b);
      @(negedge hclk);
      chk({31'h0, irq}, {31'h0, b});
      @(posedge hclk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // read data is settled mid data phase
   always @(negedge hclk) begin
      n_lost += ev_lost;
      n_miss += ev_miss;
      n_out += ev_out;
      if (rd_ph && exp_q.size() > 0) begin
         chk(hrdata, exp_q.pop_front());
         chk({31'h0, hresp}, 32'h0);
      end
   end
   always @(posedge hclk) rd_ph <= hsel && htrans[1] && !hwrite && hready;
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      complete_run;
   end
   initial begin
      void'($urandom(32'h5ba3));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(0, `TFEM_OFS_CTRL, 32'h0);
      xfer(0, `TFEM_OFS_IRQ_MASK, 32'h0);
      xfer(1, 8'h20, $urandom);
      xfer(0, 8'h20, 32'h0);
      for (int s = 0; s < 4; s++) begin
         xfer(1, `TFEM_OFS_CTRL, 32'(s << 2));
         xfer(0, `TFEM_OFS_CTRL, 32'(s << 2));
         tick(s);
         tick(s ^ 1);
         e_out++;
      end
      skip <= 1'b1;
      tick(0);
      tick(0);
      e_miss++;
      xfer(0, `TFEM_OFS_COUNT, 32'h4);
      xfer(0, `TFEM_OFS_STATUS, 32'h1);
      xfer(0, `TFEM_OFS_STATUS, 32'h1);
      xfer(1, `TFEM_OFS_CMD, 32'h5);
      xfer(0, `TFEM_OFS_STATUS, 32'h0);
      xfer(0, `TFEM_OFS_COUNT, 32'h0);
      for (int m = 0; m < 3; m++) begin
         xfer(1, `TFEM_OFS_CTRL, 32'(m << 4));
         tick(4);
         tick(5);
         e_lost += int'(m < 2);
      end
      xfer(0, `TFEM_OFS_STATUS, 32'h2);
      xfer(0, `TFEM_OFS_STATUS, 32'h2);
      xfer(1, `TFEM_OFS_CMD, 32'h2);
      xfer(0, `TFEM_OFS_STATUS, 32'h0);
      irq_is(1'b0);
      xfer(1, `TFEM_OFS_IRQ_MASK, 32'h7);
      irq_is(1'b1);
      xfer(0, `TFEM_OFS_IRQ_STAT, 32'h7);
      irq_is(1'b0);
      xfer(1, `TFEM_OFS_IRQ_MASK, 32'h4);
      skip <= 1'b0;
      tick(0);
      e_out++;
      e_miss++;
      irq_is(1'b1);
      xfer(0, `TFEM_OFS_IRQ_STAT, 32'h6);
      irq_is(1'b0);
      chk(32'(n_out), 32'(e_out));
      chk(32'(n_miss), 32'(e_miss));
      chk(32'(n_lost), 32'(e_lost));
      complete_run;
   end
endmodule
`default_nettype wire
